// >>> pkg/trace_pkg.sv
package trace_pkg;

  localparam int CHAN_W     = 16;
  localparam int THR_W      = 8;
  localparam int ADDR_W     = 8;
  localparam int NCLK       = 5;
  localparam int NPIN       = 6;
  localparam int FIFO_DEPTH = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_THR_LO  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_THR_HI  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CLKSEL  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DATA    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PATTERN = 8'h18;

  // Control bits
  localparam int CTRL_MODE   = 0;
  localparam int CTRL_INIT   = 1;
  localparam int CTRL_ARM_EN = 2;
  localparam int CTRL_RUN    = 3;

  // Status bits
  localparam int ST_MODE     = 0;
  localparam int ST_AVAIL    = 1;
  localparam int ST_FULL     = 2;
  localparam int ST_ARMED    = 3;
  localparam int ST_TRIG     = 4;
  localparam int ST_RANGE    = 5;
  localparam int ST_REFUSED  = 6;
  localparam int ST_OVERFLOW = 7;

  // Threshold field: signed 50 mV steps, preset select above it
  localparam int THR_PRESET_LSB = 16;
  localparam int DATA_VALID_BIT = 16;
  localparam int PAT_MASK_LSB   = 16;

  localparam logic [1:0] PRESET_NONE = 2'h0;
  localparam logic [1:0] PRESET_TTL  = 2'h1;
  localparam logic [1:0] PRESET_CMOS = 2'h2;
  localparam logic [1:0] PRESET_NEG  = 2'h3;

  localparam logic [THR_W-1:0] THR_TTL                   = 8'h1C;
  localparam logic [THR_W-1:0] THR_CMOS                  = 8'h32;
  localparam logic [THR_W-1:0] preset_threshold_negative = 8'hE6;

  // Clock pin indices; edge select is two bits per clock
  localparam int CLK_A     = 0;
  localparam int CLK_B     = 1;
  localparam int CLK_L     = 2;
  localparam int CLK_M     = 3;
  localparam int CLK_N     = 4;
  localparam int PIN_TRACE = 5;

  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [2*NCLK-1:0] CLKSEL_RESET = 10'h001;

  typedef enum logic {MODE_EXTENSION, MODE_INDEPENDENT} mode_t;

  function automatic logic [THR_W-1:0] preset_code(input logic [1:0] p);
    case (p)
      PRESET_CMOS: preset_code = THR_CMOS;
      PRESET_NEG:  preset_code = preset_threshold_negative;
      default:     preset_code = THR_TTL;
    endcase
  endfunction

endpackage

// >>> src/trace_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module trace_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push;
  wire              load;

  // Depth must be a power of two; pointers wrap naturally
  assign in_ready = (count != FULL_COUNT);
  assign push     = in_valid && in_ready;
  assign load     = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(load);
      count  <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // Head word is held in a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (flush) begin
      out_valid <= 1'b0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> src/external_state_trace_frontend.sv
// Overview of operation
// R1: Sixteen probe data channels and two probe clocks are captured as trace data; only the 16 data channels are stored, the clocks only time samples.
// R2: Lower group 0-7 with clock A, upper group 8-15 with clock B.
// R3: Thresholds span -6.4 V to 6.35 V in 50 mV steps; others rejected.
// R4: Both thresholds default to 1.4 V; 2.5 V and -1.3 V presets offered.
// R5: Reset or trace initialisation puts the unit into extension mode.
// R6: In extension mode data is sampled on the emulation trace clock.
// R7: Extension mode accepts only threshold, label and mode operations.
// R8: Operator should not use probe clocks as emulation trace clock.
// R9: Independent mode stores 16-bit samples into its own trace memory.
// R10: Either analyzer can arm the other; arm qualifies sample storage.
// R11: Mode select switches modes; extension mode re-selectable any time.
// R12: Independent clock chosen among probe clocks A, B and emulator L, M, N.
// R13: Each selected clock samples on rising, falling or both edges.
// R14: Configured edges of all selected clocks are ORed into samples.
// R15: Clocks are synchronously sampled; one word stored per qualifying edge.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module external_state_trace_frontend #(
  parameter int FIFO_DEPTH = trace_pkg::FIFO_DEPTH
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic [31:0]                       hrdata,
  input  wire logic [trace_pkg::CHAN_W-1:0] probe_data,
  input  wire logic                         probe_clock_a,
  input  wire logic                         probe_clock_b,
  input  wire logic                         emul_clock_l,
  input  wire logic                         emul_clock_m,
  input  wire logic                         emul_clock_n,
  input  wire logic                         emul_trace_clock,
  input  wire logic                         arm_in,
  output logic [trace_pkg::CHAN_W-1:0]      ext_trace_data,
  output logic                              ext_trace_valid,
  output logic [trace_pkg::THR_W-1:0]       threshold_lower,
  output logic [trace_pkg::THR_W-1:0]       threshold_upper,
  output logic                              mode_independent,
  output logic                              arm_out
);
  import trace_pkg::*;

  mode_t                mode;
  logic                 arm_enable;
  logic                 run;
  logic                 armed;
  logic [2*NCLK-1:0]    clk_edge_sel;
  logic [31:0]          pattern;
  logic                 range_err;
  logic                 refused;
  logic                 overflow;
  logic                 wr_pending;
  logic [ADDR_W-1:0]    wr_addr;
  logic [NPIN-1:0]      pin_meta;
  logic [NPIN-1:0]      pin_sync;
  logic [NPIN-1:0]      pin_prev;
  logic [CHAN_W-1:0]    data_meta;
  logic [CHAN_W-1:0]    data_sync;
  wire  [NCLK-1:0]      clk_hit;
  logic [31:0]          next_rdata;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [CHAN_W-1:0]    fifo_out_data;

  wire [NPIN-1:0]   pin_raw;
  wire              ahb_go;
  wire              rd_go;
  wire [ADDR_W-1:0] rd_addr;
  wire              is_ext;
  wire              wr_ctrl;
  wire              wr_thr_lo;
  wire              wr_thr_hi;
  wire              wr_clksel;
  wire              wr_pattern;
  wire              wr_status;
  wire              do_init;
  wire              thr_ok;
  wire [1:0]        thr_preset;
  wire [THR_W-1:0]  next_thr;
  wire              thr_take;
  wire              thr_bad;
  wire              cfg_refused;
  wire              rd_data;
  wire              rd_refused;
  wire              fifo_pop;
  wire              indep_event;
  wire              ext_event;
  wire              capture_ok;
  wire              store;
  wire              lost;
  wire              pat_match;
  wire              run_start;
  wire [31:0]       status_word;

  // Pin synchronisers
  assign pin_raw = {emul_trace_clock, emul_clock_n, emul_clock_m,
                    emul_clock_l, probe_clock_b, probe_clock_a};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta  <= '0;
      pin_sync  <= '0;
      pin_prev  <= '0;
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      pin_meta  <= pin_raw;
      pin_sync  <= pin_meta;
      pin_prev  <= pin_sync;
      data_meta <= probe_data; // R1
      data_sync <= data_meta; // R1
    end
  end

  // Per-clock edge detection and selection
  generate
    for (genvar i = 0; i < NCLK; i++) begin : g_clk
      wire rise = pin_sync[i] && !pin_prev[i];
      wire fall = !pin_sync[i] && pin_prev[i];
      assign clk_hit[i] = (clk_edge_sel[2*i] && rise) // R13
                       || (clk_edge_sel[2*i+1] && fall); // R12
    end
  endgenerate

  assign indep_event = |clk_hit; // R14
  assign ext_event   = pin_sync[PIN_TRACE] && !pin_prev[PIN_TRACE];

  // Bus decode
  assign ahb_go     = hsel && htrans[1] && hready;
  assign rd_go      = ahb_go && !hwrite;
  assign rd_addr    = haddr[ADDR_W-1:0];
  assign is_ext     = (mode == MODE_EXTENSION);
  assign wr_ctrl    = wr_pending && (wr_addr == OFF_CTRL);
  assign wr_thr_lo  = wr_pending && (wr_addr == OFF_THR_LO);
  assign wr_thr_hi  = wr_pending && (wr_addr == OFF_THR_HI);
  assign wr_clksel  = wr_pending && (wr_addr == OFF_CLKSEL);
  assign wr_pattern = wr_pending && (wr_addr == OFF_PATTERN);
  assign wr_status  = wr_pending && (wr_addr == OFF_STATUS);
  assign do_init    = wr_ctrl && hwdata[CTRL_INIT];
  assign run_start  = wr_ctrl && hwdata[CTRL_MODE] && hwdata[CTRL_RUN]
                      && !do_init;

  // Threshold value must fit signed 8-bit steps unless a preset is used
  assign thr_preset = hwdata[THR_PRESET_LSB+1:THR_PRESET_LSB];
  assign thr_ok     = (hwdata[15:7] == 9'h000) || (hwdata[15:7] == 9'h1FF); // R3
  assign thr_take   = (thr_preset != PRESET_NONE) || thr_ok;
  assign thr_bad    = (wr_thr_lo || wr_thr_hi) && !thr_take; // R3
  assign next_thr   = (thr_preset != PRESET_NONE) ? preset_code(thr_preset)
                                                   : hwdata[THR_W-1:0]; // R4

  // Independent-only operations are refused in extension mode
  assign cfg_refused = is_ext && (wr_clksel || wr_pattern
                       || (wr_ctrl && !hwdata[CTRL_MODE]
                           && (hwdata[CTRL_ARM_EN] || hwdata[CTRL_RUN]))); // R7
  assign rd_data     = rd_go && (rd_addr == OFF_DATA);
  assign rd_refused  = rd_data && is_ext; // R7
  assign fifo_pop    = rd_data && !is_ext;

  // Storage qualifier
  assign capture_ok = !is_ext && run && armed; // R10
  assign store      = capture_ok && indep_event && fifo_in_ready; // R15
  assign lost       = capture_ok && indep_event && !fifo_in_ready;
  assign pat_match  = ((data_sync ^ pattern[CHAN_W-1:0])
                       & pattern[PAT_MASK_LSB+CHAN_W-1:PAT_MASK_LSB]) == '0;

  assign status_word = {24'h000000, overflow, refused, range_err, arm_out,
                        armed, !fifo_in_ready, fifo_out_valid, mode};

  always_comb begin
    case (rd_addr)
      OFF_CTRL:    next_rdata = {28'h0000000, run, arm_enable, 1'b0, mode};
      OFF_THR_LO:  next_rdata = {24'h000000, threshold_lower};
      OFF_THR_HI:  next_rdata = {24'h000000, threshold_upper};
      OFF_CLKSEL:  next_rdata = {22'h000000, clk_edge_sel};
      OFF_STATUS:  next_rdata = status_word;
      OFF_DATA:    next_rdata = is_ext ? 32'h00000000 // R7
                   : {15'h0000, fifo_pop && fifo_out_valid, fifo_out_data};
      OFF_PATTERN: next_rdata = pattern;
      default:     next_rdata = 32'h00000000;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h00000000;
      wr_pending <= 1'b0;
      wr_addr    <= '0;
    end else begin
      wr_pending <= ahb_go && hwrite;
      if (ahb_go) begin
        wr_addr <= rd_addr;
      end
      if (rd_go) begin
        hrdata <= next_rdata;
      end
    end
  end

  // Mode and run control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode       <= MODE_EXTENSION; // R5
      arm_enable <= 1'b0;
      run        <= 1'b0;
    end else if (do_init) begin
      mode       <= MODE_EXTENSION; // R5
      arm_enable <= 1'b0;
      run        <= 1'b0;
    end else if (wr_ctrl) begin
      mode       <= hwdata[CTRL_MODE] ? MODE_INDEPENDENT
                                      : MODE_EXTENSION; // R11
      arm_enable <= hwdata[CTRL_MODE] && hwdata[CTRL_ARM_EN];
      run        <= hwdata[CTRL_MODE] && hwdata[CTRL_RUN];
    end
  end

  // Thresholds per group
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      threshold_lower <= THR_TTL; // R4
      threshold_upper <= THR_TTL; // R4
    end else begin
      if (wr_thr_lo && thr_take) begin
        threshold_lower <= next_thr; // R2
      end
      if (wr_thr_hi && thr_take) begin
        threshold_upper <= next_thr; // R2
      end
    end
  end

  // Independent configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_edge_sel <= CLKSEL_RESET;
      pattern      <= 32'h00000000;
    end else if (do_init) begin
      clk_edge_sel <= CLKSEL_RESET;
      pattern      <= 32'h00000000;
    end else if (!is_ext) begin
      if (wr_clksel) begin
        clk_edge_sel <= hwdata[2*NCLK-1:0]; // R12
      end
      if (wr_pattern) begin
        pattern <= hwdata;
      end
    end
  end

  // Cross arming
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed   <= 1'b0;
      arm_out <= 1'b0;
    end else if (do_init || run_start) begin
      armed   <= 1'b0;
      arm_out <= 1'b0;
    end else begin
      if (run && (!arm_enable || arm_in)) begin
        armed <= 1'b1; // R10
      end
      if (store && pat_match) begin
        arm_out <= 1'b1; // R10
      end
    end
  end

  // Sticky flags: write one to clear, a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_err <= 1'b0;
      refused   <= 1'b0;
      overflow  <= 1'b0;
    end else begin
      range_err <= thr_bad || (range_err && !(wr_status && hwdata[ST_RANGE]));
      refused   <= cfg_refused || rd_refused
                   || (refused && !(wr_status && hwdata[ST_REFUSED]));
      overflow  <= lost
                   || (overflow && !(wr_status && hwdata[ST_OVERFLOW]));
    end
  end

  // Extension mode output, sampled on the emulation trace clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_trace_data   <= '0;
      ext_trace_valid  <= 1'b0;
      mode_independent <= 1'b0;
    end else begin
      ext_trace_valid  <= is_ext && ext_event; // R6
      if (is_ext && ext_event) begin
        ext_trace_data <= data_sync; // R6
      end
      mode_independent <= !is_ext;
    end
  end

  // Independent trace memory
  trace_fifo #(.WIDTH(CHAN_W), .DEPTH(FIFO_DEPTH)) u_trace_mem (
    .clk       (hclk),
    .rst_n     (hresetn),
    .flush     (do_init || run_start),
    .in_valid  (store), // R9
    .in_data   (data_sync),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rise_a_seq;
    !pin_sync[CLK_A] ##1 pin_sync[CLK_A];
  endsequence
  sequence fall_b_seq;
    pin_sync[CLK_B] ##1 !pin_sync[CLK_B];
  endsequence
  AST_INIT_EXT: assert property (do_init |=> mode == MODE_EXTENSION
      ##1 mode_independent == 1'b0) // R5
    else $error("init did not return to extension mode");
  AST_MODE_SEL: assert property (wr_ctrl && !do_init
      |=> mode == mode_t'($past(hwdata[CTRL_MODE]))) // R11
    else $error("mode select not applied");
  AST_EXT_SAMPLE: assert property (is_ext && ext_event
      |=> ext_trace_valid && ext_trace_data == $past(data_sync)) // R6
    else $error("extension sample missing");
  AST_EXT_REFUSE: assert property (is_ext && wr_clksel
      |=> $stable(clk_edge_sel) && refused) // R7
    else $error("clock select changed in extension mode");
  AST_THR_RANGE: assert property (thr_bad
      |=> $stable(threshold_lower) && $stable(threshold_upper)
          && range_err) // R3
    else $error("out of range threshold accepted");
  AST_THR_PRESET: assert property (wr_thr_lo && thr_preset == PRESET_NEG
      |=> threshold_lower == preset_threshold_negative
          && $stable(threshold_upper)) // R2
    else $error("negative preset not applied to lower group");
  AST_THR_CMOS: assert property (wr_thr_hi && thr_preset == PRESET_CMOS
      |=> threshold_upper == THR_CMOS) // R4
    else $error("second preset not applied");
  AST_RISE_STORE: assert property (rise_a_seq ##0 !pin_prev[CLK_A]
      && clk_edge_sel[2*CLK_A] && capture_ok && fifo_in_ready && !wr_ctrl
      |=> ##1 fifo_out_valid || $past(wr_ctrl)) // R13
    else $error("rising edge of clock A not stored");
  AST_OR_FALL: assert property (fall_b_seq ##0 pin_prev[CLK_B]
      && clk_edge_sel[2*CLK_B+1] && capture_ok |-> store || lost) // R14
    else $error("falling edge of clock B not ORed in");
  AST_NO_EXT_STORE: assert property (is_ext |-> !store ##1 !store) // R15
    else $error("sample stored in extension mode");
  AST_ARM: assert property (run && arm_enable && !armed && arm_in
      && !wr_ctrl |=> armed ##1 armed) // R10
    else $error("arm input did not arm the unit");
endmodule
`default_nettype wire

// >>> tb/probe_model.sv
`timescale 1ns/10ps
`default_nettype none
module probe_model (
  output var logic [15:0] probe_data,
  output var logic [5:0]  pins
);
  initial begin
    probe_data = 16'h0000;
    pins       = 6'h00;
  end

  // One 205 ns link period; clocks stand still between frames
  task automatic frame(input logic [5:0] which, input logic [15:0] d);
    #5;
    probe_data = d;
    #50;
    pins = which;
    #100;
    pins = 6'h00;
    #50;
    probe_data = ~d;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import trace_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] probe_data;
  logic [5:0]  pins;
  logic        arm_in;
  logic [15:0] ext_trace_data;
  logic        ext_trace_valid;
  logic [7:0]  threshold_lower;
  logic [7:0]  threshold_upper;
  logic        mode_independent;
  logic        arm_out;
  int          errors;
  int          num_checks;
  int          seed;
  int          ext_cnt;
  int          n0;
  logic [15:0] ext_last;
  logic [31:0] rd;
  logic [31:0] r;
  logic [15:0] q[$];
  logic [31:0] tw[6] = '{32'h7F, 32'hFF80, 32'h80, 32'h10000, 32'h20000,
                         32'h30000};
  logic [7:0]  te[6] = '{8'h7F, 8'h80, 8'h80, 8'h1C, 8'h32, 8'hE6};
  logic [9:0]  sels[8] = '{10'h001, 10'h008, 10'h030, 10'h0C0, 10'h100,
                           10'h009, 10'h005, 10'h001};
  logic [5:0]  whs[8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h03, 6'h03,
                          6'h02};

  external_state_trace_frontend u_external_state_trace_frontend (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .probe_data(probe_data),
    .probe_clock_a(pins[CLK_A]), .probe_clock_b(pins[CLK_B]),
    .emul_clock_l(pins[CLK_L]), .emul_clock_m(pins[CLK_M]),
    .emul_clock_n(pins[CLK_N]), .emul_trace_clock(pins[PIN_TRACE]),
    .arm_in(arm_in), .ext_trace_data(ext_trace_data),
    .ext_trace_valid(ext_trace_valid), .threshold_lower(threshold_lower),
    .threshold_upper(threshold_upper), .mode_independent(mode_independent),
    .arm_out(arm_out)
  );
  probe_model u_probe_model (.probe_data(probe_data), .pins(pins));

  always #12.5 hclk = ~hclk;

  always @(posedge hclk) begin
    if (ext_trace_valid === 1'b1) begin
      ext_cnt  <= ext_cnt + 1;
      ext_last <= ext_trace_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    repeat (2) @(posedge hclk);
  endtask

  function automatic int nsamp(logic [9:0] sel, logic [5:0] w);
    int rs;
    int fs;
    rs = 0;
    fs = 0;
    for (int i = 0; i < NCLK; i++) begin
      if (w[i] && sel[2*i]) rs = 1;
      if (w[i] && sel[2*i+1]) fs = 1;
    end
    return rs + fs;
  endfunction

  // Drive one link frame and update the expected trace memory
  task automatic frame(input logic [9:0] sel, input logic [5:0] w,
                       input logic st, input logic [15:0] d);
    u_probe_model.frame(w, d);
    if (st) begin
      for (int i = 0; i < nsamp(sel, w); i++) begin
        if (q.size() < FIFO_DEPTH + 1) q.push_back(d);
      end
    end
    repeat (4) @(posedge hclk);
  endtask

  task automatic drain();
    while (q.size() > 0) begin
      ahb(1'b0, OFF_DATA, 32'h0);
      chk(rd, {15'h0000, 1'b1, q.pop_front()});
    end
    ahb(1'b0, OFF_DATA, 32'h0);
    chk(rd & 32'h10000, 32'h0);
  endtask

  task automatic restart(input logic [31:0] ctrl);
    ahb(1'b1, OFF_CTRL, ctrl);
    q.delete();
  endtask

  task automatic done(input string s);
    $display("test %0s done", s);
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    errors++;
    conclude();
  end

  initial begin
    seed = 19;
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    arm_in = 1'b0;
    errors = 0;
    num_checks = 0;
    ext_cnt = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({24'h0, threshold_lower}, 32'h1C);
    chk({24'h0, threshold_upper}, 32'h1C);
    chk({31'h0, mode_independent}, 32'h0);
    done("reset");
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, OFF_THR_LO, tw[i]);
      chk({24'h0, threshold_lower}, {24'h0, te[i]});
    end
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h20, 32'h20);
    r = $random(seed);
    ahb(1'b1, OFF_THR_HI, {16'h0000, {8{r[7]}}, r[7:0]});
    chk({24'h0, threshold_upper}, {24'h0, r[7:0]});
    chk({24'h0, threshold_lower}, 32'hE6);
    ahb(1'b1, OFF_THR_HI, 32'h20000);
    chk({24'h0, threshold_upper}, 32'h32);
    done("threshold");
    ahb(1'b1, OFF_CLKSEL, 32'h3FF);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h40, 32'h40);
    ahb(1'b1, OFF_STATUS, 32'h60);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h60, 32'h0);
    ahb(1'b1, OFF_CTRL, 32'h8);
    ahb(1'b0, OFF_CLKSEL, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h41, 32'h40);
    ahb(1'b0, OFF_DATA, 32'h0);
    chk(rd, 32'h0);
    n0 = ext_cnt;
    r = $random(seed);
    frame(10'h001, 6'h21, 1'b0, r[15:0]);
    chk(ext_cnt - n0, 32'h1);
    chk({16'h0, ext_last}, {16'h0, r[15:0]});
    done("extension");
    ahb(1'b1, OFF_CTRL, 32'h1);
    chk({31'h0, mode_independent}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, OFF_CLKSEL, {22'h0, sels[i]});
      restart(32'h9);
      frame(sels[i], whs[i], 1'b1, 16'($random(seed)));
      drain();
    end
    done("clock select");
    ahb(1'b1, OFF_CLKSEL, 32'h1);
    restart(32'h9);
    for (int i = 0; i < 34; i++) begin
      frame(10'h001, 6'h01, 1'b1, 16'($random(seed)));
    end
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h86, 32'h86);
    drain();
    done("overflow");
    restart(32'hD);
    frame(10'h001, 6'h01, 1'b0, 16'($random(seed)));
    drain();
    @(posedge hclk);
    arm_in <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({31'h0, arm_out}, 32'h0);
    frame(10'h001, 6'h01, 1'b1, 16'($random(seed)));
    chk({31'h0, arm_out}, 32'h1);
    drain();
    ahb(1'b1, OFF_PATTERN, 32'hFFFF1234);
    restart(32'hD);
    frame(10'h001, 6'h01, 1'b1, 16'h0001);
    chk({31'h0, arm_out}, 32'h0);
    frame(10'h001, 6'h01, 1'b1, 16'h1234);
    chk({31'h0, arm_out}, 32'h1);
    drain();
    done("arm");
    ahb(1'b1, OFF_CTRL, 32'h0);
    chk({31'h0, mode_independent}, 32'h0);
    ahb(1'b1, OFF_CTRL, 32'h1);
    ahb(1'b1, OFF_CTRL, 32'h2);
    chk({31'h0, mode_independent}, 32'h0);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    ahb(1'b0, OFF_DATA, 32'h0);
    chk(rd, 32'h0);
    done("mode");
    conclude();
  end
endmodule
`default_nettype wire
